// File: src/dbsp_fifo.sv
// Purpose: small first-in first-out buffer with valid/ready on both sides
// Assumes: one clock, synchronous active-low reset
// Notes:   pointers carry one extra bit so full and empty are exact
`timescale 1ns/1ps
`default_nettype none
module dbsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW:0]                 wp;
        logic [PW:0]                 rp;
    } dbsp_fifo_state_type;

    dbsp_fifo_state_type st;
    dbsp_fifo_state_type next_st;
    logic                full;
    logic                empty;

    assign full      = (st.wp[PW] != st.rp[PW]) && (st.wp[PW-1:0] == st.rp[PW-1:0]);
    assign empty     = (st.wp == st.rp);
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = st.mem[st.rp[PW-1:0]];

    always_comb begin
        next_st = st;
        if (in_valid && !full) begin
            next_st.mem[st.wp[PW-1:0]] = in_data;
            next_st.wp                 = st.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            next_st.rp = st.rp + 1'b1;
        end
        if (!rst_n) begin
            next_st = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        st <= next_st;
    end

    fifo_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        full |=> !(st.wp == st.rp))
        else $error("fifo wrapped to empty while full");
endmodule : dbsp_fifo
`default_nettype wire

// File: src/dbsp_pkg.sv
// Purpose: shared constants for the burst-of-four double-data-rate memory port
// Assumes: 36-bit data path, 9-bit bytes, storage cut down to a small index
// Notes:   latencies are counted in half cycles of the input clock pair
package dbsp_pkg;
    localparam int ADDR_W          = 20;
    localparam int WIDE_ADDR_W     = 19;
    localparam int DATA_W          = 36;
    localparam int NARROW_W        = 18;
    localparam int BYTE_W          = 9;
    localparam int BYTE_N          = 4;
    localparam int NARROW_BYTE_N   = 2;
    localparam int WORD_W          = 2;
    localparam logic [1:0] BURST_LAST = 2'h3;
    // storage index bits taken from the low end of the burst address
    localparam int IDX_W           = 4;
    localparam int MEM_DEPTH       = 1 << (IDX_W + WORD_W);
    // first read word, in half cycles after the request edge
    localparam int LAT_LOOP_HALF   = 5;
    localparam int LAT_BYPASS_HALF = 2;
    localparam int TAP_LOOP        = LAT_LOOP_HALF - 1;
    localparam int TAP_BYPASS      = LAT_BYPASS_HALF - 1;
    localparam int RPIPE_N         = LAT_LOOP_HALF;
    // first write word, in half cycles after the request edge
    localparam int WR_LAT_HALF     = 2;
    localparam int WPIPE_N         = WR_LAT_HALF;
    // loop lock time, in input clock cycles
    localparam logic [11:0] LOCK_K_CYCLES = 12'h400;
    localparam int FIFO_DEPTH      = 8;
    localparam int ENTRY_W         = IDX_W + WORD_W + DATA_W + BYTE_N;
endpackage : dbsp_pkg

// File: src/dbsp_port.sv
// Purpose: device end of a burst-of-four double-data-rate static memory port
// Assumes: input clock pair and all pins sampled by sys_clk, far slower than it
// Notes:   storage holds only the low address bits; write words pass a buffer
//
// Function
// [RULE_01] address and requests taken on true-clock rise
// [RULE_02] write data on both clock rises
// [RULE_03] echo clocks run always, even idle
// [RULE_04] echo edges aligned with read data
// [RULE_05] loop disable low bypasses, clears lock
// [RULE_06] loop enable starts lock count
// [RULE_07] bypassed loop gives one-cycle read latency
// [RULE_08] valid flag marks read data, echo aligned
// [RULE_09] address ignored without a request
// [RULE_10] narrow organisation uses write bits 0-17
// [RULE_11] narrow organisation drives read bits 0-17
// [RULE_12] read outputs driven only for reads
// [RULE_13] write request latches address, starts write
// [RULE_14] read request latches address, starts read
// [RULE_15] first read word 2.5 cycles later
// [RULE_16] reads no closer than every other cycle
// [RULE_17] write words start one cycle later
// [RULE_18] low byte strobe enables that byte
// [RULE_19] address 19 bits wide, 20 narrow
`timescale 1ns/1ps
`default_nettype none
module dbsp_port
    import dbsp_pkg::*;
(
    // clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    // input clock pair from the controller
    input  wire logic                in_clk_true,
    input  wire logic                in_clk_comp,
    // requests and address
    input  wire logic                read_req_n,
    input  wire logic                write_req_n,
    input  wire logic [ADDR_W-1:0]   sync_address,
    // write side
    input  wire logic [DATA_W-1:0]   write_data,
    input  wire logic [BYTE_N-1:0]   byte_write_strobe_n,
    output logic                     write_buffer_ready,
    // read side
    output logic [DATA_W-1:0]        read_data,
    output logic                     read_data_oe,
    output logic                     output_valid,
    output logic                     echo_timing_pos,
    output logic                     echo_timing_neg,
    // loop control and organisation strap
    input  wire logic                loop_disable_n,
    input  wire logic                org_narrow,
    output logic                     loop_locked
);

    typedef struct packed {
        // two-stage input synchronisers, plus a third stage for the clocks
        logic                                  k_s1;
        logic                                  k_s2;
        logic                                  k_s3;
        logic                                  kn_s1;
        logic                                  kn_s2;
        logic                                  kn_s3;
        logic                                  r_s1;
        logic                                  r_s2;
        logic                                  w_s1;
        logic                                  w_s2;
        logic [ADDR_W-1:0]                     a_s1;
        logic [ADDR_W-1:0]                     a_s2;
        logic [DATA_W-1:0]                     d_s1;
        logic [DATA_W-1:0]                     d_s2;
        logic [BYTE_N-1:0]                     bw_s1;
        logic [BYTE_N-1:0]                     bw_s2;
        logic                                  off_s1;
        logic                                  off_s2;
        logic                                  org_s1;
        logic                                  org_s2;
        // read request pipeline, one step per half cycle
        logic [RPIPE_N-1:0]                    rv;
        logic [RPIPE_N-1:0][IDX_W-1:0]         ra;
        logic                                  out_active;
        logic [WORD_W-1:0]                     out_cnt;
        logic [IDX_W-1:0]                      out_addr;
        logic [DATA_W-1:0]                     q;
        logic                                  q_oe;
        logic                                  valid;
        logic                                  echo_p;
        logic                                  echo_n;
        // write request pipeline and word capture
        logic [WPIPE_N-1:0]                    wv;
        logic [WPIPE_N-1:0][IDX_W-1:0]         wa;
        logic                                  cap_active;
        logic [WORD_W-1:0]                     cap_cnt;
        logic [IDX_W-1:0]                      cap_addr;
        // loop state
        logic [11:0]                           lock_cnt;
        logic                                  locked;
        // storage
        logic [MEM_DEPTH-1:0][DATA_W-1:0]      mem;
    } dbsp_state_type;

    dbsp_state_type            st;
    dbsp_state_type            next_st;

    logic                      k_rise;
    logic                      kn_rise;
    logic                      half_edge;
    logic                      rd_req;
    logic                      wr_req;
    logic                      bypass;
    logic [ADDR_W-1:0]         eff_addr;
    logic [IDX_W-1:0]          addr_idx;
    logic                      tap_valid;
    logic [IDX_W-1:0]          tap_addr;
    logic                      launch;
    logic [IDX_W+WORD_W-1:0]   launch_idx;
    logic [DATA_W-1:0]         wmask;
    logic                      push;
    logic [ENTRY_W-1:0]        push_entry;
    logic                      drain_valid;
    logic                      drain_ready;
    logic [ENTRY_W-1:0]        drain_entry;

    // edges of the synchronised clock pair; the first stage is never read here
    assign k_rise    = st.k_s2 & ~st.k_s3;
    assign kn_rise   = st.kn_s2 & ~st.kn_s3;
    assign half_edge = k_rise | kn_rise;
    assign rd_req    = k_rise & ~st.r_s2;                                      // RULE_01 RULE_14
    assign wr_req    = k_rise & ~st.w_s2;                                      // RULE_01 RULE_13
    assign bypass    = ~st.off_s2;                                             // RULE_05

    // wide organisation has no top address bit
    assign eff_addr  = st.org_s2 ? st.a_s2
                                 : {1'b0, st.a_s2[WIDE_ADDR_W-1:0]};           // RULE_19
    assign addr_idx  = eff_addr[IDX_W-1:0];

    // first word picked from the pipeline stage that matches the latency mode
    assign tap_valid = bypass ? st.rv[TAP_BYPASS] : st.rv[TAP_LOOP];          // RULE_07 RULE_15
    assign tap_addr  = bypass ? st.ra[TAP_BYPASS] : st.ra[TAP_LOOP];

    // the narrow organisation only ever sees the low half of the data bus
    assign wmask     = st.org_s2 ? {{(DATA_W-NARROW_W){1'b0}}, {NARROW_W{1'b1}}}
                                 : {DATA_W{1'b1}};                             // RULE_10 RULE_11

    // one storage access per cycle: a read launch holds the buffer back
    assign drain_ready = ~launch;

    always_comb begin
        next_st    = st;
        launch     = 1'b0;
        launch_idx = '0;
        push       = 1'b0;
        push_entry = '0;

        // synchronisers
        next_st.k_s1   = in_clk_true;
        next_st.k_s2   = st.k_s1;
        next_st.k_s3   = st.k_s2;
        next_st.kn_s1  = in_clk_comp;
        next_st.kn_s2  = st.kn_s1;
        next_st.kn_s3  = st.kn_s2;
        next_st.r_s1   = read_req_n;
        next_st.r_s2   = st.r_s1;
        next_st.w_s1   = write_req_n;
        next_st.w_s2   = st.w_s1;
        next_st.a_s1   = sync_address;
        next_st.a_s2   = st.a_s1;
        next_st.d_s1   = write_data;
        next_st.d_s2   = st.d_s1;
        next_st.bw_s1  = byte_write_strobe_n;
        next_st.bw_s2  = st.bw_s1;
        next_st.off_s1 = loop_disable_n;
        next_st.off_s2 = st.off_s1;
        next_st.org_s1 = org_narrow;
        next_st.org_s2 = st.org_s1;

        // echo clocks follow the clock pair with the same delay as the data
        next_st.echo_p = st.k_s2;                                              // RULE_03 RULE_04
        next_st.echo_n = st.kn_s2;                                             // RULE_03 RULE_04

        // loop: bypass wipes lock state, enable counts true-clock cycles
        if (bypass) begin
            next_st.lock_cnt = '0;                                             // RULE_05
            next_st.locked   = 1'b0;
        end else if (k_rise && !st.locked) begin
            next_st.lock_cnt = st.lock_cnt + 12'h001;                          // RULE_06
            if (st.lock_cnt == LOCK_K_CYCLES - 12'h001) begin
                next_st.locked = 1'b1;
            end
        end

        if (half_edge) begin
            // read pipeline; address only stored when a request is active
            for (int i = RPIPE_N - 1; i > 0; i--) begin
                next_st.rv[i] = st.rv[i-1];
                next_st.ra[i] = st.ra[i-1];
            end
            next_st.rv[0] = rd_req;
            next_st.ra[0] = rd_req ? addr_idx : '0;                            // RULE_09

            // write pipeline
            for (int i = WPIPE_N - 1; i > 0; i--) begin
                next_st.wv[i] = st.wv[i-1];
                next_st.wa[i] = st.wa[i-1];
            end
            next_st.wv[0] = wr_req;
            next_st.wa[0] = wr_req ? addr_idx : '0;                            // RULE_09

            // output burst; a new burst's first word cuts off any burst still running
            if (tap_valid) begin                                               // RULE_16
                launch             = 1'b1;
                launch_idx         = {tap_addr, {WORD_W{1'b0}}};
                next_st.out_active = 1'b1;
                next_st.out_addr   = tap_addr;
                next_st.out_cnt    = {{(WORD_W-1){1'b0}}, 1'b1};
            end else if (st.out_active) begin
                launch          = 1'b1;                                        // RULE_15
                launch_idx      = {st.out_addr, st.out_cnt};
                next_st.out_cnt = st.out_cnt + 1'b1;
                if (st.out_cnt == BURST_LAST) begin
                    next_st.out_active = 1'b0;
                end
            end

            // write words on every rise of either clock, one cycle late
            if (st.wv[WPIPE_N-1]) begin                                        // RULE_17
                push               = 1'b1;
                push_entry         = {st.wa[WPIPE_N-1], {WORD_W{1'b0}},
                                      st.d_s2 & wmask, st.bw_s2};              // RULE_02
                next_st.cap_active = 1'b1;
                next_st.cap_addr   = st.wa[WPIPE_N-1];
                next_st.cap_cnt    = {{(WORD_W-1){1'b0}}, 1'b1};
            end else if (st.cap_active) begin
                push            = 1'b1;                                        // RULE_02
                push_entry      = {st.cap_addr, st.cap_cnt,
                                   st.d_s2 & wmask, st.bw_s2};
                next_st.cap_cnt = st.cap_cnt + 1'b1;
                if (st.cap_cnt == BURST_LAST) begin
                    next_st.cap_active = 1'b0;
                end
            end
        end

        // read data leaves only for launched words
        if (launch) begin
            next_st.q     = st.mem[launch_idx] & wmask;                        // RULE_11 RULE_12
            next_st.q_oe  = 1'b1;                                              // RULE_12
            next_st.valid = 1'b1;                                              // RULE_08
        end else if (half_edge) begin
            next_st.q     = '0;
            next_st.q_oe  = 1'b0;
            next_st.valid = 1'b0;
        end

        // buffered write into storage, byte by byte
        if (drain_valid && drain_ready) begin
            for (int b = 0; b < BYTE_N; b++) begin
                // narrow organisation has only the two low strobes
                if (!drain_entry[b] && (!st.org_s2 || b < NARROW_BYTE_N)) begin  // RULE_18
                    next_st.mem[drain_entry[ENTRY_W-1:DATA_W+BYTE_N]]
                               [b*BYTE_W +: BYTE_W] =
                        drain_entry[BYTE_N + b*BYTE_W +: BYTE_W];
                end
            end
        end

        if (!rst_n) begin
            next_st      = '0;
            next_st.r_s1 = 1'b1;
            next_st.r_s2 = 1'b1;
            next_st.w_s1 = 1'b1;
            next_st.w_s2 = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        st <= next_st;
    end

    // a full buffer drops the word; the controller sees it on write_buffer_ready
    dbsp_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (FIFO_DEPTH)
    ) u_write_buffer (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (push),
        .in_ready  (write_buffer_ready),
        .in_data   (push_entry),
        .out_valid (drain_valid),
        .out_ready (drain_ready),
        .out_data  (drain_entry)
    );

    assign read_data       = st.q;
    assign read_data_oe    = st.q_oe;
    assign output_valid    = st.valid;
    assign echo_timing_pos = st.echo_p;
    assign echo_timing_neg = st.echo_n;
    assign loop_locked     = st.locked;

    // timing checks assume an 80 ns input clock period
    rd_cmd_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_14
        rd_req |=> st.rv[0] && st.ra[0] == $past(addr_idx))
        else $error("read request not latched");

    addr_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_09
        (k_rise && st.r_s2 && st.w_s2) |=> !st.rv[0] && !st.wv[0])
        else $error("idle edge started an access");

    rd_latency_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_15
        (rd_req && !bypass && $stable(bypass)) |-> ##[19:21] read_data_oe)
        else $error("read data not at 2.5 cycles");

    bypass_lat_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_07
        (rd_req && bypass && $stable(bypass)) |-> ##[7:9] read_data_oe)
        else $error("bypass read data not at one cycle");

    echo_run_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_03
        k_rise |=> echo_timing_pos && !$past(echo_timing_pos))
        else $error("echo clock stopped");

    echo_align_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_04
        $rose(output_valid) |-> $changed(echo_timing_pos) || $changed(echo_timing_neg))
        else $error("read data not on an echo edge");

    valid_oe_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_08
        output_valid == read_data_oe)
        else $error("valid flag and data drive disagree");

    bypass_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_05
        bypass |=> !loop_locked && st.lock_cnt == '0)
        else $error("lock state kept while bypassed");

    lock_time_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_06
        $rose(loop_locked) |-> $past(st.lock_cnt) == LOCK_K_CYCLES - 12'h001)
        else $error("loop locked early");

    narrow_q_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_11
        (st.org_s2 && $past(st.org_s2)) |-> read_data[DATA_W-1:NARROW_W] == '0)
        else $error("narrow organisation drove upper bits");

    wr_capture_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_13
        wr_req |-> ##[7:9] push)
        else $error("write words not captured one cycle later");
endmodule : dbsp_port
`default_nettype wire

// File: tb/dbsp_ctrl.sv
// Purpose: controller-side model: input clock pair, bursts, read capture
// Assumes: 80 ns input clock pair, free running, phase unrelated to sys_clk
// Notes:   released address, data and strobe lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module dbsp_ctrl
    import dbsp_pkg::*;
(
    // capture clock
    input  wire logic              sys_clk,
    // link towards the port
    output logic                   in_clk_true,
    output logic                   in_clk_comp,
    output logic                   read_req_n,
    output logic                   write_req_n,
    output logic [ADDR_W-1:0]      sync_address,
    output logic [DATA_W-1:0]      write_data,
    output logic [BYTE_N-1:0]      byte_write_strobe_n,
    // read return
    input  wire logic [DATA_W-1:0] read_data,
    input  wire logic              output_valid,
    input  wire logic              echo_timing_pos,
    input  wire logic              echo_timing_neg
);
    logic [DATA_W-1:0] got[$];
    int                cyc = 0;
    int                req_cyc = 0;
    int                vld_cyc = 0;
    logic              last_pos = 1'b0;
    logic              last_neg = 1'b0;
    logic              last_vld = 1'b0;

    initial begin
        in_clk_true = 1'b0;
        in_clk_comp = 1'b1;
        read_req_n = 1'b1;
        write_req_n = 1'b1;
        sync_address = '0;
        write_data = '0;
        byte_write_strobe_n = '1;
        #3;
        forever begin
            #40;
            in_clk_true = ~in_clk_true;
            in_clk_comp = ~in_clk_true;
        end
    end

    always @(posedge in_clk_true) begin
        if (!read_req_n) begin
            req_cyc <= cyc;
        end
    end

    // a word is taken each time an echo edge lands while valid is high
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (output_valid && !last_vld) begin
            vld_cyc <= cyc;
        end
        if (output_valid && (echo_timing_pos != last_pos || echo_timing_neg != last_neg)) begin
            got.push_back(read_data);
        end
        last_pos <= echo_timing_pos;
        last_neg <= echo_timing_neg;
        last_vld <= output_valid;
    end

    // request at one true rise, then four words one cycle later
    task automatic burst(input logic rd, input logic wr, input logic [ADDR_W-1:0] a,
                         input logic [BYTE_N-1:0] s, input logic [3:0][DATA_W-1:0] w);
        @(negedge in_clk_true);
        read_req_n = ~rd;
        write_req_n = ~wr;
        sync_address = a;
        @(negedge in_clk_true);
        read_req_n = 1'b1;
        write_req_n = 1'b1;
        sync_address = ~a;
        for (int i = 0; i < 4; i++) begin
            write_data = w[i];
            byte_write_strobe_n = s;
            if (i == 0 || i == 2) begin
                @(posedge in_clk_true);
            end else begin
                @(posedge in_clk_comp);
            end
            #20;
        end
        write_data = ~w[3];
        byte_write_strobe_n = ~s;
    endtask : burst
endmodule : dbsp_ctrl
`default_nettype wire

// File: tb/test_ddr_burst4_sram_port.sv
// Purpose: self-checking bench for the burst-of-four memory port
// Assumes: 100 MHz sys_clk, 80 ns input clock pair from the model
// Notes:   latency windows count sys cycles from the true-clock rise that takes the request
`timescale 1ns/1ps
`default_nettype none
module test_ddr_burst4_sram_port
    import dbsp_pkg::*;
;
    logic                sys_clk = 1'b0;
    logic                rst_n = 1'b0;
    logic                loop_disable_n = 1'b1;
    logic                org_narrow = 1'b0;
    logic                in_clk_true, in_clk_comp, read_req_n, write_req_n;
    logic                write_buffer_ready, read_data_oe, output_valid, loop_locked;
    logic                echo_timing_pos, echo_timing_neg;
    logic [ADDR_W-1:0]   sync_address;
    logic [DATA_W-1:0]   write_data, read_data;
    logic [BYTE_N-1:0]   byte_write_strobe_n;
    logic [3:0][DATA_W-1:0] w1 = {36'h987654321, 36'h123456789, 36'hF0F0F0F0F, 36'hA5A5A5A5A};
    logic [3:0][DATA_W-1:0] w2 = {36'h0DEADBEEF, 36'hFFFFFFFFF, 36'h3C3C3C3C3, 36'h111111111};
    int                  failures = 0;
    int                  n_compared = 0;

    always #5 sys_clk = ~sys_clk;

    dbsp_port dut (.sys_clk, .rst_n, .in_clk_true, .in_clk_comp, .read_req_n, .write_req_n,
        .sync_address, .write_data, .byte_write_strobe_n, .write_buffer_ready, .read_data,
        .read_data_oe, .output_valid, .echo_timing_pos, .echo_timing_neg, .loop_disable_n,
        .org_narrow, .loop_locked);
    dbsp_ctrl ctrl (.sys_clk, .in_clk_true, .in_clk_comp, .read_req_n, .write_req_n,
        .sync_address, .write_data, .byte_write_strobe_n, .read_data, .output_valid,
        .echo_timing_pos, .echo_timing_neg);

    task automatic check(input string name, input logic [DATA_W-1:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic do_reset();
        @(negedge sys_clk);
        rst_n = 1'b0;
        repeat (8) @(negedge sys_clk);
        check("rst_oe", {read_data_oe, output_valid, loop_locked}, 0);
        check("rst_data", read_data, 0);
        check("rst_ready", write_buffer_ready, 1);
        rst_n = 1'b1;
        repeat (12) @(negedge sys_clk);
    endtask : do_reset

    // read a burst back, compare words, latency and release afterwards
    task automatic rd_check(input logic [ADDR_W-1:0] a, input logic [3:0][DATA_W-1:0] e,
                            input int lo, input int hi);
        int lat;
        ctrl.got.delete();
        ctrl.burst(1'b1, 1'b0, a, 4'hF, w2);
        for (int i = 0; i < 100 && ctrl.got.size() < 4; i++) @(negedge sys_clk);
        if (ctrl.got.size() < 4) begin
            failures++;
            finish_test();
        end
        for (int i = 0; i < 4; i++) check("rd_word", ctrl.got[i], e[i]);
        lat = ctrl.vld_cyc - ctrl.req_cyc;
        check("rd_latency", lat >= lo && lat <= hi, 1);
        repeat (12) @(negedge sys_clk);
        check("rd_release", {read_data_oe, output_valid}, 0);
        check("rd_release_q", read_data, 0);
    endtask : rd_check

    task automatic t_idle_echo();
        int   tog = 0;
        logic p;
        p = echo_timing_pos;
        repeat (40) begin
            @(negedge sys_clk);
            tog += (echo_timing_pos !== p);
            p = echo_timing_pos;
        end
        check("echo_runs", tog >= 8, 1);
        check("idle_oe", read_data_oe, 0);
        $display("test idle_echo done");
    endtask : t_idle_echo

    task automatic t_bytes();
        logic [DATA_W-1:0]      m = 36'h007FC01FF;
        logic [3:0][DATA_W-1:0] e;
        // words left from the last read would look like a stray burst
        ctrl.got.delete();
        ctrl.burst(1'b0, 1'b1, 20'h5, 4'h0, w1);
        ctrl.burst(1'b0, 1'b1, 20'h5, 4'hA, w2);
        // address and low strobes with no request must change nothing
        ctrl.burst(1'b0, 1'b0, 20'h5, 4'h0, ~w1);
        check("no_req_out", ctrl.got.size(), 0);
        for (int i = 0; i < 4; i++) e[i] = (w2[i] & m) | (w1[i] & ~m);
        rd_check(20'h5, e, 20, 25);
        $display("test bytes done");
    endtask : t_bytes

    task automatic t_lock();
        int n = 0;
        @(negedge sys_clk);
        loop_disable_n = 1'b0;
        repeat (10) @(negedge sys_clk);
        loop_disable_n = 1'b1;
        while (loop_locked !== 1'b1 && n < 8600) begin
            @(negedge sys_clk);
            n++;
        end
        check("lock_time", n >= 8100 && n <= 8300, 1);
        if (loop_locked !== 1'b1) begin
            finish_test();
        end
        loop_disable_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        check("lock_clear", loop_locked, 0);
        loop_disable_n = 1'b1;
        repeat (100) @(negedge sys_clk);
        check("lock_restart", loop_locked, 0);
        $display("test lock done");
    endtask : t_lock

    initial begin
        do_reset();
        t_idle_echo();
        ctrl.burst(1'b0, 1'b1, 20'h3, 4'h0, w1);
        rd_check(20'h3, w1, 20, 25);
        $display("test write_read done");
        t_bytes();
        loop_disable_n = 1'b0;
        repeat (20) @(negedge sys_clk);
        rd_check(20'h3, w1, 8, 13);
        loop_disable_n = 1'b1;
        $display("test bypass done");
        t_lock();
        org_narrow = 1'b1;
        do_reset();
        ctrl.burst(1'b0, 1'b1, 20'h7, 4'h0, w1);
        rd_check(20'h7, w1 & {4{36'h00003FFFF}}, 20, 25);
        $display("test narrow done");
        finish_test();
    end
endmodule : test_ddr_burst4_sram_port
`default_nettype wire
